/* File: dv/flash_status_register_bank_tb.sv */
module flash_status_register_bank_tb
   import fsr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic       core_clk = 1'h0;
   logic       srst     = 1'h1;
   logic       soft_rst = 1'h0;
   logic       wp_pin_n = 1'h1;
   logic       op_done  = 1'h0;
   logic       clk_en   = 1'h1;
   logic       cmd_valid;
   fsr_cmd_t   cmd;
   logic       op_start_q;
   logic       op_suspend_q;
   logic       op_resume_q;
   fsr_cfg_t   cfg_out_q;
   logic [2:0] lock_out_q;
   logic       wp_fn_en_q;
   logic       busy_q;
   logic [7:0] status_reg_one;
   logic [7:0] status_reg_two;
   int         errors       = 0;
   int         total_checks = 0;
   int         starts       = 0;
   int         susps        = 0;
   int         resumes      = 0;

   always #50 core_clk = ~core_clk;

   fsr_host_model fsr_host_model_inst (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd));

   fsr_status_bank #(.NV_CYC(8)) fsr_status_bank_inst (
      .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
      .soft_rst(soft_rst), .wp_pin_n(wp_pin_n), .op_done(op_done), .op_start_q(op_start_q),
      .op_suspend_q(op_suspend_q), .op_resume_q(op_resume_q), .cfg_out_q(cfg_out_q),
      .lock_out_q(lock_out_q), .wp_fn_en_q(wp_fn_en_q), .busy_q(busy_q),
      .status_reg_one(status_reg_one), .status_reg_two(status_reg_two));

   // engine pulses last one cycle, so count them at every edge
   always @(posedge core_clk)
   begin
      if (op_start_q === 1'h1)
         starts++;
      if (op_suspend_q === 1'h1)
         susps++;
      if (op_resume_q === 1'h1)
         resumes++;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic settle();
      repeat (3) @(negedge core_clk);
   endtask

   task automatic pulse(ref logic sig);
      @(negedge core_clk);
      sig = 1'h1;
      @(negedge core_clk);
      sig = 1'h0;
   endtask

   task automatic do_reset();
      srst = 1'h1;
      repeat (20) @(negedge core_clk);
      srst = 1'h0;
   endtask

   // enable, status write, then wait out a possible nv cycle under a bound
   task automatic wr(input logic [7:0] en, input logic [7:0] code, input logic [7:0] b1, input logic [7:0] b2,
                     input logic two, input logic exp_busy);
      int n;
      n = 0;
      fsr_host_model_inst.send(en, 8'h00, 8'h00, 1'h0);
      fsr_host_model_inst.send(code, b1, b2, two);
      repeat (2) @(negedge core_clk);
      chk(busy_q, exp_busy, "busy after status write");
      while (busy_q !== 1'h0 && n < 200)
      begin
         @(negedge core_clk);
         n++;
      end
      chk(busy_q, 1'h0, "busy stuck");
      settle();
   endtask

   task automatic t_reset();
      chk(status_reg_one, 8'h00, "sr one default");
      chk(status_reg_two, 8'h00, "sr two default");
      chk({7'h00, cfg_out_q}, 16'h0000, "cfg default");
      chk(wp_fn_en_q, 1'h1, "pin functions on");
   endtask

   // a command seen while the enable is low must leave no trace
   task automatic t_freeze();
      clk_en = 1'h0;
      fsr_host_model_inst.send(OP_WREN, 8'h00, 8'h00, 1'h0);
      clk_en = 1'h1;
      settle();
      chk(status_reg_one, 8'h00, "wel set while frozen");
   endtask

   task automatic t_wel();
      fsr_host_model_inst.send(OP_WREN, 8'h00, 8'h00, 1'h0);
      settle();
      chk(status_reg_one, 8'h02, "wel set");
      fsr_host_model_inst.send(OP_WRDI, 8'h00, 8'h00, 1'h0);
      settle();
      chk(status_reg_one, 8'h00, "wel cleared by disable");
      fsr_host_model_inst.send(OP_WRSR, 8'h1C, 8'h00, 1'h0);
      settle();
      chk(status_reg_one, 8'h00, "write without wel");
   endtask

   task automatic t_nv_write();
      fsr_host_model_inst.send(OP_WREN, 8'h00, 8'h00, 1'h0);
      fsr_host_model_inst.send(OP_WRSR, 8'h3C, 8'h40, 1'h1);
      repeat (2) @(negedge core_clk);
      chk(status_reg_one[0], 1'h1, "busy bit during cell write");
      // enable while busy must be dropped, so wel still ends at 0
      fsr_host_model_inst.send(OP_WREN, 8'h00, 8'h00, 1'h0);
      wr(OP_WRDI, OP_WRDI, 8'h00, 8'h00, 1'h0, 1'h0);
      chk(status_reg_one, 8'h3C, "nv sr one");
      chk(status_reg_two, 8'h40, "nv sr two");
      chk({7'h00, cfg_out_q}, {7'h00, 1'h0, 1'h0, 1'h1, 3'h7, 1'h1, 1'h0, 1'h0}, "cfg");
   endtask

   task automatic t_volatile();
      wr(OP_VWREN, OP_WRSR, 8'h00, 8'h00, 1'h1, 1'h0);
      chk(status_reg_one, 8'h00, "volatile sr one");
      chk(status_reg_two, 8'h00, "volatile sr two");
      pulse(soft_rst);
      settle();
      chk(status_reg_one, 8'h3C, "reload sr one");
      chk(status_reg_two, 8'h40, "reload sr two");
   endtask

   task automatic t_locks();
      wr(OP_WREN, OP_WRSR2, 8'h7A, 8'h00, 1'h0, 1'h1);
      chk(status_reg_two, 8'h7A, "locks and quad");
      chk(lock_out_q, 3'h7, "lock out");
      chk(wp_fn_en_q, 1'h0, "pin functions off");
      wr(OP_WREN, OP_WRSR2, 8'h40, 8'h00, 1'h0, 1'h1);
      chk(status_reg_two, 8'h78, "locks stay set");
      chk(wp_fn_en_q, 1'h1, "pin functions back");
   endtask

   task automatic t_guard();
      wr(OP_WREN, OP_WRSR, 8'hBC, 8'h00, 1'h0, 1'h1);
      wp_pin_n = 1'h0;
      repeat (6) @(negedge core_clk);
      wr(OP_WREN, OP_WRSR, 8'h3C, 8'h00, 1'h0, 1'h0);
      chk(status_reg_one[7:2], 6'h2F, "pin lock");
      wp_pin_n = 1'h1;
      repeat (6) @(negedge core_clk);
      fsr_host_model_inst.send(OP_WRDI, 8'h00, 8'h00, 1'h0);
      wr(OP_WREN, OP_WRSR, 8'h00, 8'h79, 1'h1, 1'h1);
      chk(status_reg_one, 8'h00, "pin high write");
      wr(OP_WREN, OP_WRSR, 8'h1C, 8'h78, 1'h1, 1'h0);
      chk(status_reg_one[7:2], 6'h00, "power lockdown");
      do_reset();
   endtask

   task automatic t_engine();
      logic [7:0] ops [4];
      ops = '{OP_PROG, OP_SERASE, OP_BERASE, OP_CERASE};
      fsr_host_model_inst.send(OP_PROG, 8'h00, 8'h00, 1'h0);
      settle();
      chk(starts, 0, "start without wel");
      foreach (ops[i])
      begin
         fsr_host_model_inst.send(OP_WREN, 8'h00, 8'h00, 1'h0);
         fsr_host_model_inst.send(ops[i], 8'h00, 8'h00, 1'h0);
         settle();
         chk(starts, i + 1, "op start");
         chk(status_reg_one, 8'h03, "busy with wel");
         fsr_host_model_inst.send(OP_SUSP, 8'h00, 8'h00, 1'h0);
         settle();
         chk(susps, i + 1, "suspend pulse");
         chk(status_reg_two, (i == 0) ? 8'h04 : 8'h80, "suspend flag");
         fsr_host_model_inst.send(OP_RESUME, 8'h00, 8'h00, 1'h0);
         settle();
         chk(resumes, i + 1, "resume pulse");
         chk(status_reg_two, 8'h00, "flag cleared");
         pulse(op_done);
         settle();
         chk(status_reg_one, 8'h00, "done clears busy and wel");
      end
   endtask

   // about 300 cycles expected; past 20000 cycles is a hang
   initial
   begin
      #2000000;
      errors++;
      end_of_test();
   end

   initial
   begin
      do_reset();
      t_reset();
      t_freeze();
      t_wel();
      t_nv_write();
      t_volatile();
      t_locks();
      t_guard();
      t_reset();
      t_engine();
      end_of_test();
   end
endmodule

/* File: dv/fsr_host_model.sv */
module fsr_host_model
   import fsr_pkg::*;
(
   input  wire logic core_clk,
   output logic      cmd_valid,
   output fsr_cmd_t  cmd
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end

   // one decoded command per call; callers put 06h/50h ahead of a status write, or 04h to test a refused one
   task automatic send(input logic [7:0] code, input logic [7:0] b1, input logic [7:0] b2, input logic two);
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd       = '{code, b1, b2, two};
      @(negedge core_clk);
      cmd_valid = 1'b0;
      // released lines carry inverted junk so a stale command never looks valid
      cmd       = ~cmd;
   endtask
endmodule

/* File: logic/fsr_nv_store.sv */
module fsr_nv_store
   import fsr_pkg::*;
#(
   parameter int CYC = NV_WR_CYCLES
)
(
   input  wire logic    core_clk,
   input  wire logic    srst,
   input  wire logic    clk_en,
   input  wire logic    wr_req,
   input  fsr_nv_t      wr_data,
   output fsr_nv_t      rd_q,
   output logic         busy_q,
   output logic         done_q
);
   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   logic [CW-1:0] cnt_q;
   fsr_nv_t       pend_q;

   // srst stands for a power-on with factory-blank cells
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
         pend_q <= NV_RST;
      end
      else if (clk_en)
      begin
         if (!busy_q && wr_req)
         begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
            pend_q <= wr_data;
         end
         else if (busy_q && cnt_q == LAST)
            busy_q <= 1'b0;
         else if (busy_q)
            cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_q   <= NV_RST;
         done_q <= 1'b0;
      end
      else if (clk_en)
      begin
         done_q <= busy_q && cnt_q == LAST;
         if (busy_q && cnt_q == LAST)
            rd_q <= pend_q;
      end
   end
endmodule

/* File: logic/fsr_pin_sync.sv */
module fsr_pin_sync
   import fsr_pkg::*;
#(
   parameter logic RST_VAL = 1'b1
)
(
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic clk_en,
   input  wire logic pin_in,
   output logic      pin_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end
      else if (clk_en)
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // glitch filter: only an agreed value moves the output
   always_ff @(posedge core_clk)
   begin
      if (srst)
         pin_q <= RST_VAL;
      else if (clk_en && (s2_q == s3_q))
         pin_q <= s3_q;
   end
endmodule

/* File: logic/fsr_pkg.sv */
package fsr_pkg;
   localparam logic [7:0] OP_WREN   = 8'h06;
   localparam logic [7:0] OP_VWREN  = 8'h50;
   localparam logic [7:0] OP_WRDI   = 8'h04;
   localparam logic [7:0] OP_WRSR   = 8'h01;
   localparam logic [7:0] OP_WRSR2  = 8'h31;
   localparam logic [7:0] OP_PROG   = 8'h02;
   localparam logic [7:0] OP_SERASE = 8'h20;
   localparam logic [7:0] OP_BERASE = 8'hD8;
   localparam logic [7:0] OP_CERASE = 8'hC7;
   localparam logic [7:0] OP_SUSP   = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;

   // bit positions in status_reg_one
   localparam int S1_GUARD0 = 7;
   localparam int S1_SECT   = 6;
   localparam int S1_TOPBOT = 5;
   localparam int S1_AREA_H = 4;
   localparam int S1_AREA_L = 2;
   localparam int S1_WEL    = 1;
   localparam int S1_BUSY   = 0;
   // bit positions in status_reg_two
   localparam int S2_ESUS   = 7;
   localparam int S2_CMAP   = 6;
   localparam int S2_LOCK_H = 5;
   localparam int S2_LOCK_L = 3;
   localparam int S2_PSUS   = 2;
   localparam int S2_QUAD   = 1;
   localparam int S2_GUARD1 = 0;

   typedef struct packed {
      logic       reg_guard_bit_zero;
      logic       sector_or_block_select;
      logic       top_or_bottom_select;
      logic [2:0] area_guard;
      logic       complement_map_select;
      logic       four_lane_enable;
      logic       reg_guard_bit_one;
   } fsr_cfg_t;

   typedef struct packed {
      fsr_cfg_t   cfg;
      logic [2:0] secure_lock;
   } fsr_nv_t;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic       two;
   } fsr_cmd_t;

   localparam fsr_cfg_t   CFG_RST  = '0;
   localparam fsr_nv_t    NV_RST   = '0;
   localparam logic [7:0] SR_RST   = 8'h00;

   localparam int NV_WR_TIME_US = 5000;
   localparam int CLK_MHZ       = 10;
   localparam int NV_WR_CYCLES  = NV_WR_TIME_US * CLK_MHZ;
endpackage

/* File: logic/fsr_status_bank.sv */
// Summary of operation
// - sr1[7:2], sr2[6:3,1,0] held non-volatile
// - busy, wel, suspend flags volatile read-only
// - wel set by 06h, cleared at completion
// - nv write needs guard bits and enable
// - volatile config copies load at power/reset
// - 50h then status write: volatile only
// - sector select: 64 KB blocks or 4 KB
// - top/bottom bit picks region growth direction
// - area guard field, zero means unprotected
// - busy during operations, commands other than suspend ignored
// - wel cleared by disable, program, erase, write
// - no embedded operation without wel set
// - sr2 bit7 erase, bit2 program suspended
// - complement bit inverts the protection map
// - sr2[5:3] one-time lock bits
// - quad bit turns off protect/pause pins
// - two guard bits pick write protection scheme
// - every bit defaults to zero
// - top/bottom change needs guard bits, wel or 50h
// - guard codes: soft, pin, lockdown, permanent
// - suspend sets flags, resume clears them
module fsr_status_bank
   import fsr_pkg::*;
#(
   parameter int NV_CYC = NV_WR_CYCLES
)
(
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic clk_en,
   input  wire logic cmd_valid,
   input  fsr_cmd_t  cmd,
   input  wire logic soft_rst,
   input  wire logic wp_pin_n,
   input  wire logic op_done,
   output logic      op_start_q,
   output logic      op_suspend_q,
   output logic      op_resume_q,
   output fsr_cfg_t  cfg_out_q,
   output logic [2:0] lock_out_q,
   output logic      wp_fn_en_q,
   output logic      busy_q,
   output logic [7:0] status_reg_one,
   output logic [7:0] status_reg_two
);
   fsr_cfg_t cfg_q;
   fsr_nv_t  nv_rd;
   fsr_nv_t  nv_wdata_q;
   logic     nv_busy;
   logic     nv_done;
   logic     nv_req_q;
   logic     wp_n_s;
   logic     wel_q;
   logic     vwel_q;
   logic     eng_busy_q;
   logic     eng_erase_q;
   logic     erase_suspended_flag_q;
   logic     program_suspended_flag_q;

   fsr_pin_sync #(.RST_VAL(1'b1)) u_wp_sync
   (
      .core_clk (core_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .pin_in   (wp_pin_n),
      .pin_q    (wp_n_s)
   );

   fsr_nv_store #(.CYC(NV_CYC)) u_nv
   (
      .core_clk (core_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .wr_req   (nv_req_q),
      .wr_data  (nv_wdata_q),
      .rd_q     (nv_rd),
      .busy_q   (nv_busy),
      .done_q   (nv_done)
   );

   logic busy_now;
   logic acc;
   logic is_wrsr;
   logic is_op;
   logic wr_allow;
   logic susp_ok;
   logic res_ok;
   logic any_susp;
   fsr_cfg_t new_cfg;
   logic [2:0] new_lock;
   logic [7:0] sr1_in;
   logic [7:0] sr2_in;

   assign busy_now = eng_busy_q | nv_busy | nv_req_q;
   assign any_susp = erase_suspended_flag_q | program_suspended_flag_q;
   // only status reads (served from the outputs) and suspend (75h, via susp_ok) pass while busy
   assign acc      = clk_en & cmd_valid & ~busy_now;
   assign susp_ok  = clk_en & cmd_valid & cmd.code == OP_SUSP & eng_busy_q & ~any_susp;
   assign res_ok   = acc & cmd.code == OP_RESUME & any_susp;
   assign is_wrsr  = cmd.code == OP_WRSR || cmd.code == OP_WRSR2;
   assign is_op    = cmd.code == OP_PROG || cmd.code == OP_SERASE
                     || cmd.code == OP_BERASE || cmd.code == OP_CERASE;

   // the quad lanes take over the protect pin, so it stops counting
   always_comb
   begin
      case ({cfg_q.reg_guard_bit_one, cfg_q.reg_guard_bit_zero})
         2'b00:   wr_allow = 1'b1;
         2'b01:   wr_allow = wp_n_s | cfg_q.four_lane_enable;
         2'b10:   wr_allow = 1'b0;
         default: wr_allow = 1'b0;
      endcase
   end

   always_comb
   begin
      sr1_in = {cfg_q.reg_guard_bit_zero, cfg_q.sector_or_block_select,
                cfg_q.top_or_bottom_select, cfg_q.area_guard, 2'b00};
      sr2_in = {1'b0, cfg_q.complement_map_select, 3'b000, 1'b0,
                cfg_q.four_lane_enable, cfg_q.reg_guard_bit_one};
      if (cmd.code == OP_WRSR)
      begin
         sr1_in = cmd.byte1;
         if (cmd.two)
            sr2_in = cmd.byte2;
      end
      else
         sr2_in = cmd.byte1;
      new_cfg.reg_guard_bit_zero     = sr1_in[S1_GUARD0];
      new_cfg.sector_or_block_select = sr1_in[S1_SECT];
      new_cfg.top_or_bottom_select   = sr1_in[S1_TOPBOT];
      new_cfg.area_guard             = sr1_in[S1_AREA_H:S1_AREA_L];
      new_cfg.complement_map_select  = sr2_in[S2_CMAP];
      new_cfg.four_lane_enable       = sr2_in[S2_QUAD];
      new_cfg.reg_guard_bit_one      = sr2_in[S2_GUARD1];
      new_lock = nv_rd.secure_lock;
      if (cmd.code == OP_WRSR2 || cmd.two)
         new_lock = nv_rd.secure_lock | sr2_in[S2_LOCK_H:S2_LOCK_L];
   end

   logic nv_go;
   logic vol_go;
   assign nv_go  = acc & is_wrsr & wel_q & ~vwel_q & wr_allow;
   assign vol_go = acc & is_wrsr & vwel_q & wr_allow;

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         nv_req_q   <= 1'b0;
         nv_wdata_q <= NV_RST;
      end
      else if (clk_en)
      begin
         nv_req_q <= nv_go;
         if (nv_go)
            nv_wdata_q <= '{cfg: new_cfg, secure_lock: new_lock};
      end
   end

   // volatile copies steer protection; locks have no volatile copy
   always_ff @(posedge core_clk)
   begin
      if (srst)
         cfg_q <= CFG_RST;
      else if (clk_en)
      begin
         if (soft_rst)
            cfg_q <= nv_rd.cfg;
         else if (vol_go)
            cfg_q <= new_cfg;
         else if (nv_done)
            cfg_q <= nv_wdata_q.cfg;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         wel_q <= 1'b0;
      else if (clk_en)
      begin
         if (soft_rst)
            wel_q <= 1'b0;
         else if (acc && cmd.code == OP_WREN)
            wel_q <= 1'b1;
         else if (acc && (cmd.code == OP_WRDI || (is_wrsr && !nv_go)))
            wel_q <= 1'b0;
         else if (nv_done || (op_done && eng_busy_q))
            wel_q <= 1'b0;
      end
   end

   // the volatile enable lives only until the next accepted command
   always_ff @(posedge core_clk)
   begin
      if (srst)
         vwel_q <= 1'b0;
      else if (clk_en)
      begin
         if (soft_rst)
            vwel_q <= 1'b0;
         else if (acc)
            vwel_q <= cmd.code == OP_VWREN;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         op_start_q  <= 1'b0;
         eng_busy_q  <= 1'b0;
         eng_erase_q <= 1'b0;
      end
      else if (clk_en)
      begin
         op_start_q <= 1'b0;
         if (acc && is_op && wel_q && !any_susp)
         begin
            op_start_q  <= 1'b1;
            eng_busy_q  <= 1'b1;
            eng_erase_q <= cmd.code != OP_PROG;
         end
         else if (susp_ok)
            eng_busy_q <= 1'b0;
         else if (res_ok)
            eng_busy_q <= 1'b1;
         else if (op_done)
            eng_busy_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         erase_suspended_flag_q   <= 1'b0;
         program_suspended_flag_q <= 1'b0;
         op_suspend_q             <= 1'b0;
         op_resume_q              <= 1'b0;
      end
      else if (clk_en)
      begin
         op_suspend_q <= susp_ok;
         op_resume_q  <= res_ok;
         if (susp_ok)
         begin
            erase_suspended_flag_q   <= eng_erase_q;
            program_suspended_flag_q <= ~eng_erase_q;
         end
         else if (res_ok)
         begin
            erase_suspended_flag_q   <= 1'b0;
            program_suspended_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cfg_out_q  <= CFG_RST;
         lock_out_q <= 3'h0;
         wp_fn_en_q <= 1'b1;
         busy_q     <= 1'b0;
      end
      else if (clk_en)
      begin
         cfg_out_q  <= cfg_q;
         lock_out_q <= nv_rd.secure_lock;
         wp_fn_en_q <= ~cfg_q.four_lane_enable;
         busy_q     <= busy_now;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         status_reg_one <= SR_RST;
         status_reg_two <= SR_RST;
      end
      else if (clk_en)
      begin
         status_reg_one <= {cfg_q.reg_guard_bit_zero, cfg_q.sector_or_block_select,
                            cfg_q.top_or_bottom_select, cfg_q.area_guard,
                            wel_q, busy_now};
         status_reg_two <= {erase_suspended_flag_q, cfg_q.complement_map_select,
                            nv_rd.secure_lock, program_suspended_flag_q,
                            cfg_q.four_lane_enable, cfg_q.reg_guard_bit_one};
      end
   end

   sequence s_wren_taken;
      acc && cmd.code == OP_WREN;
   endsequence

   sequence s_wrsr_locked;
      acc && is_wrsr && cfg_q.reg_guard_bit_one && !nv_done && !soft_rst;
   endsequence

   a_wel_set_cmd: assert property (@(posedge core_clk) disable iff (srst)
      s_wren_taken |=> wel_q ##1 (status_reg_one[S1_WEL] || !clk_en))
      else $error("write enable command did not set latch");

   a_wel_clear_wrdi: assert property (@(posedge core_clk) disable iff (srst)
      acc && cmd.code == OP_WRDI |=> !wel_q)
      else $error("write disable left latch set");

   a_start_needs_wel: assert property (@(posedge core_clk) disable iff (srst)
      $rose(op_start_q) |-> $past(wel_q))
      else $error("operation started without write enable");

   a_busy_ignores: assert property (@(posedge core_clk) disable iff (srst)
      clk_en && cmd_valid && busy_now && !wel_q |=> !wel_q && !op_start_q)
      else $error("command taken while busy");

   a_guard_lock: assert property (@(posedge core_clk) disable iff (srst)
      s_wrsr_locked |=> !nv_req_q && $stable(cfg_q))
      else $error("status write passed a locked guard");

   a_vol_only: assert property (@(posedge core_clk) disable iff (srst)
      vol_go |=> !nv_req_q ##1 !nv_busy)
      else $error("volatile write started a cell write");

   a_pin_guard: assert property (@(posedge core_clk) disable iff (srst)
      acc && is_wrsr && wel_q && !vwel_q && !wp_n_s && !cfg_q.four_lane_enable
      && {cfg_q.reg_guard_bit_one, cfg_q.reg_guard_bit_zero} == 2'b01 |=> !nv_req_q)
      else $error("protect pin did not block status write");

   a_susp_flags: assert property (@(posedge core_clk) disable iff (srst)
      susp_ok |=> (erase_suspended_flag_q != program_suspended_flag_q) && !eng_busy_q)
      else $error("suspend flags wrong after suspend");

   a_reset_zero: assert property (@(posedge core_clk)
      $past(srst) && !srst |-> status_reg_one == SR_RST && status_reg_two == SR_RST)
      else $error("status registers not zero after reset");
endmodule
